// [kdm_menu_ctrl.sv]
// keypad and second display line menu controller
`timescale 1ns/1ps
`default_nettype none

module kdm_menu_ctrl #(
  parameter int unsigned TICK_CYCLES = kdm_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // pushbutton pins, high while pressed
  input  wire logic                           keyDownPin,
  input  wire logic                           keyUpPin,
  input  wire logic                           keyModePin,
  input  wire logic                           keyLevelPin,
  // message state from the sequencer
  input  wire logic                           preemptPresent,
  input  wire logic                           lockoutPresent,
  // quantities to show
  input  wire logic [7:0]                     flameTenths,
  input  wire logic [kdm_pkg::VAL_W-1:0]      totalCycles,
  input  wire logic [kdm_pkg::VAL_W-1:0]      totalHours,
  input  wire logic [kdm_pkg::VAL_W-1:0]      faultCycle,
  input  wire logic [kdm_pkg::VAL_W-1:0]      faultHours,
  input  wire logic [7:0]                     faultCode,
  // selection held in nonvolatile memory
  input  wire logic [3:0]                     restoredTop,
  input  wire logic [2:0]                     restoredSub,
  input  wire logic                           restoredLevel,
  // display selection
  output logic      [3:0]                     topItem,
  output logic      [2:0]                     subItem,
  output logic                                subLevel,
  output logic      [2:0]                     faultRecSel,
  output logic                                showPreempt,
  output logic                                showSaving,
  output logic      [4*kdm_pkg::DIGITS-1:0]   valueDigits,
  // save to nonvolatile memory
  output logic                                saveWrite,
  output logic      [3:0]                     savedTop,
  output logic      [2:0]                     savedSub,
  output logic                                savedLevel
);

  // ------------------------------------------------------------
  // key synchronisers and edge detect
  // ------------------------------------------------------------
  logic [3:0] keyPin;
  logic [3:0] keyMeta_r;
  logic [3:0] keySync_r;
  logic [3:0] keyLast_r;
  logic [3:0] keyRise;

  assign keyPin = {keyLevelPin, keyModePin, keyUpPin, keyDownPin};

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_key
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          keyMeta_r[k] <= 1'b0;
          keySync_r[k] <= 1'b0;
          keyLast_r[k] <= 1'b0;
        end else begin
          keyMeta_r[k] <= keyPin[k];
          keySync_r[k] <= keyMeta_r[k];
          keyLast_r[k] <= keySync_r[k];
        end
      end
      assign keyRise[k] = keySync_r[k] & ~keyLast_r[k];
    end
  endgenerate

  // ------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------
  logic [31:0] tickCnt_r;
  logic [31:0] tickCnt_nxt;
  logic        msTick;

  always_comb begin
    msTick      = (tickCnt_r == TICK_CYCLES - 1);
    tickCnt_nxt = msTick ? 32'h0 : tickCnt_r + 32'h1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) tickCnt_r <= 32'h0;
    else          tickCnt_r <= tickCnt_nxt;
  end

  // ------------------------------------------------------------
  // menu state
  // ------------------------------------------------------------
  kdm_pkg::kdm_state_t state_r, state_nxt;
  logic [3:0]  top_r, top_nxt;
  logic [2:0]  sub_r, sub_nxt;
  logic        lvl_r, lvl_nxt;
  logic [15:0] idleMs_r, idleMs_nxt;
  logic [15:0] repMs_r, repMs_nxt;
  logic [15:0] saveMs_r, saveMs_nxt;
  logic        saveWr_r, saveWr_nxt;
  logic [3:0]  savTop_r, savTop_nxt;
  logic [2:0]  savSub_r, savSub_nxt;
  logic        savLvl_r, savLvl_nxt;
  logic        showPre_r, showPre_nxt, showSav_r, showSav_nxt;
  logic        scrollHeld, scrollPress, step, goUp, msgPresent, isFault, chord;

  always_comb begin
    state_nxt   = state_r;
    top_nxt     = top_r;
    sub_nxt     = sub_r;
    lvl_nxt     = lvl_r;
    idleMs_nxt  = idleMs_r;
    repMs_nxt   = repMs_r;
    saveMs_nxt  = saveMs_r;
    saveWr_nxt  = 1'b0;
    savTop_nxt  = savTop_r;
    savSub_nxt  = savSub_r;
    savLvl_nxt  = savLvl_r;
    scrollHeld  = keySync_r[0] | keySync_r[1];
    scrollPress = keyRise[0] | keyRise[1];
    goUp        = keySync_r[1];
    msgPresent  = preemptPresent | lockoutPresent;
    isFault     = (top_r >= kdm_pkg::TOP_FAULT1);
    chord       = keySync_r[2] & keyRise[3];
    // auto repeat: one step on press, then one per half second while held
    if (!scrollHeld || scrollPress) begin
      repMs_nxt = 16'h0;
    end else if (msTick) begin
      repMs_nxt = (repMs_r == 16'(kdm_pkg::REPEAT_MS - 1)) ? 16'h0 : repMs_r + 16'h1;
    end
    step = scrollPress
         | (scrollHeld & msTick & (repMs_r == 16'(kdm_pkg::REPEAT_MS - 1)));
    // idle timer restarts on any key press
    if (|keyRise) begin
      idleMs_nxt = 16'h0;
    end else if (msTick && idleMs_r != 16'(kdm_pkg::TIMEOUT_MS - 1)) begin
      idleMs_nxt = idleMs_r + 16'h1;
    end
    unique case (state_r)
      kdm_pkg::ST_RESTORE: begin
        top_nxt   = (restoredTop > kdm_pkg::TOP_LAST) ? kdm_pkg::TOP_FLAME : restoredTop;
        sub_nxt   = (restoredSub > kdm_pkg::SUB_LAST) ? kdm_pkg::SUB_CYCLE : restoredSub;
        lvl_nxt   = restoredLevel & (restoredTop >= kdm_pkg::TOP_FAULT1)
                  & (restoredTop <= kdm_pkg::TOP_LAST);
        state_nxt = kdm_pkg::ST_BROWSE;
      end
      kdm_pkg::ST_BROWSE: begin
        if (chord) begin
          savTop_nxt = top_r;
          savSub_nxt = sub_r;
          savLvl_nxt = lvl_r;
          saveWr_nxt = 1'b1;
          saveMs_nxt = 16'h0;
          state_nxt  = kdm_pkg::ST_SAVING;
        end else if (keyRise[2] && msgPresent) begin
          state_nxt = kdm_pkg::ST_PREEMPT;
        end else if (msTick && msgPresent
                     && idleMs_r == 16'(kdm_pkg::TIMEOUT_MS - 1)) begin
          state_nxt = kdm_pkg::ST_PREEMPT;
        end else if (keyRise[3] && isFault) begin
          lvl_nxt = ~lvl_r;
          sub_nxt = kdm_pkg::SUB_CYCLE;
        end else if (step && lvl_r) begin
          if (goUp) sub_nxt = (sub_r == 3'h0) ? kdm_pkg::SUB_LAST : sub_r - 3'h1;
          else      sub_nxt = (sub_r == kdm_pkg::SUB_LAST) ? 3'h0 : sub_r + 3'h1;
        end else if (step) begin
          if (goUp) top_nxt = (top_r == 4'h0) ? kdm_pkg::TOP_LAST : top_r - 4'h1;
          else      top_nxt = (top_r == kdm_pkg::TOP_LAST) ? 4'h0 : top_r + 4'h1;
        end
      end
      kdm_pkg::ST_PREEMPT: begin
        if (chord) begin
          savTop_nxt = top_r;
          savSub_nxt = sub_r;
          savLvl_nxt = lvl_r;
          saveWr_nxt = 1'b1;
          saveMs_nxt = 16'h0;
          state_nxt  = kdm_pkg::ST_SAVING;
        end else if (!msgPresent || scrollPress) begin
          state_nxt = kdm_pkg::ST_BROWSE;
        end
      end
      kdm_pkg::ST_SAVING: begin
        if (msTick) begin
          if (saveMs_r == 16'(kdm_pkg::SAVE_SHOW_MS - 1)) state_nxt = kdm_pkg::ST_BROWSE;
          else                                             saveMs_nxt = saveMs_r + 16'h1;
        end
      end
    endcase
    showPre_nxt = (state_nxt == kdm_pkg::ST_PREEMPT);
    showSav_nxt = (state_nxt == kdm_pkg::ST_SAVING);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= kdm_pkg::ST_RESTORE;
      top_r    <= kdm_pkg::TOP_FLAME;
      sub_r    <= kdm_pkg::SUB_CYCLE;
      lvl_r    <= 1'b0;
      idleMs_r <= 16'h0;
      repMs_r  <= 16'h0;
      saveMs_r <= 16'h0;
      saveWr_r <= 1'b0;
      savTop_r <= kdm_pkg::TOP_FLAME;
      savSub_r <= kdm_pkg::SUB_CYCLE;
      savLvl_r <= 1'b0;
      showPre_r <= 1'b0;
      showSav_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      top_r    <= top_nxt;
      sub_r    <= sub_nxt;
      lvl_r    <= lvl_nxt;
      idleMs_r <= idleMs_nxt;
      repMs_r  <= repMs_nxt;
      saveMs_r <= saveMs_nxt;
      saveWr_r <= saveWr_nxt;
      savTop_r <= savTop_nxt;
      savSub_r <= savSub_nxt;
      savLvl_r <= savLvl_nxt;
      showPre_r <= showPre_nxt;
      showSav_r <= showSav_nxt;
    end
  end

  // ------------------------------------------------------------
  // value and decimal digits
  // ------------------------------------------------------------
  logic [kdm_pkg::VAL_W-1:0]    value;
  logic [4*kdm_pkg::DIGITS-1:0] digits;
  logic [4*kdm_pkg::DIGITS-1:0] digits_r;
  logic [2:0]                   recSel_r;

  always_comb begin
    value = '0;
    if (top_r == kdm_pkg::TOP_FLAME)       value = {9'h0, flameTenths};
    else if (top_r == kdm_pkg::TOP_CYCLES) value = totalCycles;
    else if (top_r == kdm_pkg::TOP_HOURS)  value = totalHours;
    else if (lvl_r && sub_r == kdm_pkg::SUB_CYCLE) value = faultCycle;
    else if (lvl_r && sub_r == kdm_pkg::SUB_HOURS) value = faultHours;
    else if (lvl_r && sub_r == kdm_pkg::SUB_CODE)  value = {9'h0, faultCode};
  end

  kdm_bcd u_bcd (
    .bin (value),
    .bcd (digits)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      digits_r <= '0;
      recSel_r <= 3'h0;
    end else begin
      digits_r <= digits;
      recSel_r <= isFault ? 3'(top_r - kdm_pkg::TOP_FAULT1) : 3'h0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign topItem     = top_r;
  assign subItem     = sub_r;
  assign subLevel    = lvl_r;
  assign faultRecSel = recSel_r;
  assign showPreempt = showPre_r;
  assign showSaving  = showSav_r;
  assign valueDigits = digits_r;
  assign saveWrite   = saveWr_r;
  assign savedTop    = savTop_r;
  assign savedSub    = savSub_r;
  assign savedLevel  = savLvl_r;

endmodule : kdm_menu_ctrl

`default_nettype wire

// [kdm_pkg.sv]
// constants shared by the keypad display menu controller
package kdm_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_S       = 60;
  localparam int unsigned TIMEOUT_MS      = TIMEOUT_S * 1000;
  localparam int unsigned REPEAT_PER_S    = 2;
  localparam int unsigned REPEAT_MS       = 1000 / REPEAT_PER_S;
  localparam int unsigned SAVE_SHOW_MS    = 1000;

  // ------------------------------------------------------------
  // menu layout
  // ------------------------------------------------------------
  localparam logic [3:0] TOP_FLAME  = 4'h0;
  localparam logic [3:0] TOP_CYCLES = 4'h1;
  localparam logic [3:0] TOP_HOURS  = 4'h2;
  localparam logic [3:0] TOP_FAULT1 = 4'h3;
  localparam logic [3:0] TOP_LAST   = 4'h8;
  localparam logic [2:0] SUB_CYCLE  = 3'h0;
  localparam logic [2:0] SUB_HOURS  = 3'h1;
  localparam logic [2:0] SUB_CODE   = 3'h2;
  localparam logic [2:0] SUB_LAST   = 3'h5;

  localparam int unsigned VAL_W   = 17;
  localparam int unsigned DIGITS  = 5;

  typedef enum logic [1:0] {
    ST_RESTORE,
    ST_BROWSE,
    ST_PREEMPT,
    ST_SAVING
  } kdm_state_t;

endpackage : kdm_pkg

// [kdm_bcd.sv]
// binary to packed decimal digit converter
`timescale 1ns/1ps
`default_nettype none

module kdm_bcd (
  // binary value in
  input  wire logic [kdm_pkg::VAL_W-1:0]    bin,
  // decimal digits out, least significant in the low nibble
  output logic      [4*kdm_pkg::DIGITS-1:0] bcd
);

  localparam int unsigned SH_W = kdm_pkg::VAL_W + 4 * kdm_pkg::DIGITS;

  logic [SH_W-1:0] sh;

  // shift and add three
  always_comb begin
    sh = '0;
    sh[kdm_pkg::VAL_W-1:0] = bin;
    for (int i = 0; i < kdm_pkg::VAL_W; i++) begin
      for (int d = 0; d < kdm_pkg::DIGITS; d++) begin
        if (sh[kdm_pkg::VAL_W + 4*d +: 4] >= 4'h5) begin
          sh[kdm_pkg::VAL_W + 4*d +: 4] = sh[kdm_pkg::VAL_W + 4*d +: 4] + 4'h3;
        end
      end
      sh = sh << 1;
    end
    bcd = sh[SH_W-1:kdm_pkg::VAL_W];
  end

endmodule : kdm_bcd

`default_nettype wire

// [kdm_menu_monitor.sv]
// assertion checker for the keypad display menu controller
`timescale 1ns/1ps
`default_nettype none

module kdm_menu_monitor (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // keys and message state
  input wire logic       keyDownPin,
  input wire logic       keyUpPin,
  input wire logic       keyModePin,
  input wire logic       keyLevelPin,
  input wire logic       preemptPresent,
  input wire logic       lockoutPresent,
  // selection and save
  input wire logic [3:0] topItem,
  input wire logic [2:0] subItem,
  input wire logic       subLevel,
  input wire logic       showPreempt,
  input wire logic       showSaving,
  input wire logic       saveWrite,
  input wire logic [3:0] savedTop,
  input wire logic [2:0] savedSub,
  input wire logic       savedLevel
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_mode_jump: assert property ($rose(keyModePin) && !keyLevelPin && !showSaving
    ##1 preemptPresent [*3] |=> showPreempt) else $error("mode press did not jump");
  chk_preempt_drop: assert property (!preemptPresent && !lockoutPresent
    |=> !showPreempt) else $error("priority shown without a message");
  chk_save_pulse: assert property (saveWrite |=> !saveWrite)
    else $error("save write longer than one cycle");
  chk_save_capture: assert property (saveWrite |-> showSaving && savedTop == topItem
    && savedSub == subItem && savedLevel == subLevel) else $error("save capture wrong");
  chk_save_cause: assert property ($rose(saveWrite) |-> $past(keyModePin, 3)
    && $past(keyLevelPin, 3) && !$past(keyLevelPin, 4)) else $error("save without chord");
  chk_saving_freeze: assert property (showSaving && $past(showSaving)
    |-> $stable(topItem) && $stable(subItem) && $stable(subLevel)) else $error("moved in save");
  chk_item_range: assert property (topItem <= 4'h8 && subItem <= 3'h5)
    else $error("item out of range");
  chk_sub_fault: assert property (subLevel |-> topItem >= 4'h3)
    else $error("sub level on a plain item");
  chk_down_step: assert property ($rose(keyDownPin) && !keyUpPin && !keyModePin
    && !keyLevelPin && !showPreempt && !showSaving && !subLevel
    |-> ##4 topItem == (($past(topItem, 4) == 4'h8) ? 4'h0 : $past(topItem, 4) + 4'h1))
    else $error("down press stepped wrongly");
endmodule : kdm_menu_monitor

bind kdm_menu_ctrl kdm_menu_monitor u_mon (
  .mclk(mclk), .reset_n(reset_n), .keyDownPin(keyDownPin), .keyUpPin(keyUpPin),
  .keyModePin(keyModePin), .keyLevelPin(keyLevelPin), .preemptPresent(preemptPresent),
  .lockoutPresent(lockoutPresent), .topItem(topItem), .subItem(subItem), .subLevel(subLevel),
  .showPreempt(showPreempt), .showSaving(showSaving), .saveWrite(saveWrite),
  .savedTop(savedTop), .savedSub(savedSub), .savedLevel(savedLevel)
);
`default_nettype wire

// [kdm_operator.sv]
// operator pressing the keys, with the nonvolatile selection store
`timescale 1ns/1ps
`default_nettype none

module kdm_operator (
  // clock
  input  wire logic       mclk,
  // pushbuttons, high while pressed
  output var  logic       keyDownPin,
  output var  logic       keyUpPin,
  output var  logic       keyModePin,
  output var  logic       keyLevelPin,
  // nonvolatile store
  input  wire logic       saveWrite,
  input  wire logic [3:0] savedTop,
  input  wire logic [2:0] savedSub,
  input  wire logic       savedLevel,
  output var  logic [3:0] restoredTop,
  output var  logic [2:0] restoredSub,
  output var  logic       restoredLevel
);
  // ------------------------------------------------------------
  // keys and store
  // ------------------------------------------------------------
  logic [3:0] keys = 4'h0;
  logic [7:0] store = 8'h00;
  assign {keyLevelPin, keyModePin, keyUpPin, keyDownPin} = keys;
  assign {restoredTop, restoredSub, restoredLevel} = store;
  // the store outlives the controller's power
  always @(posedge mclk) begin
    if (saveWrite) store <= {savedTop, savedSub, savedLevel};
  end

  // k: 0 down, 1 up, 2 mode, 3 level; called at a falling edge
  task automatic press(input int k, input int n);
    keys[k] = 1'b1;
    repeat (n) @(negedge mclk);
    keys[k] = 1'b0;
    repeat (10) @(negedge mclk);
  endtask : press

  // mode goes down first, level follows while mode is held
  task automatic save_chord();
    keys[2] = 1'b1;
    repeat (10) @(negedge mclk);
    press(3, 20);
    keys[2] = 1'b0;
    repeat (10) @(negedge mclk);
  endtask : save_chord
endmodule : kdm_operator
`default_nettype wire

// [keypad_display_menu_ctrl_tb_top.sv]
// self-checking bench for the keypad display menu controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module keypad_display_menu_ctrl_tb_top;
  // ------------------------------------------------------------
  // signals and cases
  // ------------------------------------------------------------
  typedef struct {int key; logic [3:0] top; logic [2:0] sub; logic lvl; logic [19:0] dig;} kdm_row_t;
  logic        mclk, keyDownPin, keyUpPin, keyModePin, keyLevelPin, subLevel, showPreempt;
  logic        showSaving, saveWrite, savedLevel, restoredLevel;
  logic        reset_n = 1'b0, preemptPresent = 1'b0, lockoutPresent = 1'b0;
  logic [7:0]  flameTenths = 8'h7b;
  logic [16:0] totalCycles = 17'h181cd, totalHours = 17'h010e1, faultCycle = 17'h00037;
  logic [16:0] faultHours = 17'h00007;
  logic [7:0]  faultCode = 8'hc9;
  logic [3:0]  topItem, savedTop, restoredTop;
  logic [2:0]  subItem, savedSub, restoredSub, faultRecSel, expSel;
  logic [19:0] valueDigits;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  kdm_row_t    rows [17] = '{'{0, 1, 0, 0, 'h98765}, '{0, 2, 0, 0, 'h04321}, '{0, 3, 0, 0, 0},
    '{3, 3, 0, 1, 'h55}, '{0, 3, 1, 1, 'h7}, '{0, 3, 2, 1, 'h201}, '{1, 3, 1, 1, 'h7},
    '{1, 3, 0, 1, 'h55}, '{1, 3, 5, 1, 0}, '{0, 3, 0, 1, 'h55}, '{3, 3, 0, 0, 0},
    '{1, 2, 0, 0, 'h4321}, '{1, 1, 0, 0, 'h98765}, '{1, 0, 0, 0, 'h123}, '{1, 8, 0, 0, 0},
    '{0, 0, 0, 0, 'h123}, '{3, 0, 0, 0, 'h123}};

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  kdm_menu_ctrl #(.TICK_CYCLES(1)) DUT (
    .mclk(mclk), .reset_n(reset_n), .keyDownPin(keyDownPin), .keyUpPin(keyUpPin),
    .keyModePin(keyModePin), .keyLevelPin(keyLevelPin), .preemptPresent(preemptPresent),
    .lockoutPresent(lockoutPresent), .flameTenths(flameTenths), .totalCycles(totalCycles),
    .totalHours(totalHours), .faultCycle(faultCycle), .faultHours(faultHours),
    .faultCode(faultCode), .restoredTop(restoredTop), .restoredSub(restoredSub),
    .restoredLevel(restoredLevel), .topItem(topItem), .subItem(subItem), .subLevel(subLevel),
    .faultRecSel(faultRecSel), .showPreempt(showPreempt), .showSaving(showSaving),
    .valueDigits(valueDigits), .saveWrite(saveWrite), .savedTop(savedTop),
    .savedSub(savedSub), .savedLevel(savedLevel));

  kdm_operator u_op (
    .mclk(mclk), .keyDownPin(keyDownPin), .keyUpPin(keyUpPin), .keyModePin(keyModePin),
    .keyLevelPin(keyLevelPin), .saveWrite(saveWrite), .savedTop(savedTop),
    .savedSub(savedSub), .savedLevel(savedLevel), .restoredTop(restoredTop),
    .restoredSub(restoredSub), .restoredLevel(restoredLevel));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (5) @(negedge mclk);
    foreach (rows[i]) begin
      u_op.press(rows[i].key, 20);
      `CHK("topItem", rows[i].top, topItem)
      `CHK("subLevel", rows[i].lvl, subLevel)
      if (rows[i].lvl) `CHK("subItem", rows[i].sub, subItem)
      `CHK("valueDigits", rows[i].dig, valueDigits)
      expSel = (rows[i].top >= 4'h3) ? 3'(rows[i].top - 4'h3) : 3'h0;
      `CHK("faultRecSel", expSel, faultRecSel)
    end
    flameTenths = 8'h09;
    repeat (5) @(negedge mclk);
    `CHK("valueDigits", 20'h00009, valueDigits)
    $display("menu table test done");
    u_op.press(0, 1250);
    `CHK("topItem", 4'h3, topItem)
    $display("held scroll test done");
    u_op.press(2, 20);
    `CHK("showPreempt", 1'b0, showPreempt)
    preemptPresent = 1'b1;
    u_op.press(2, 20);
    `CHK("showPreempt", 1'b1, showPreempt)
    u_op.press(0, 20);
    `CHK("showPreempt", 1'b0, showPreempt)
    preemptPresent = 1'b0;
    lockoutPresent = 1'b1;
    u_op.press(2, 20);
    `CHK("showPreempt", 1'b1, showPreempt)
    u_op.press(0, 20);
    `CHK("topItem", 4'h3, topItem)
    $display("mode key test done");
    repeat (59800) @(negedge mclk);
    `CHK("showPreempt", 1'b0, showPreempt)
    repeat (400) @(negedge mclk);
    `CHK("showPreempt", 1'b1, showPreempt)
    lockoutPresent = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("showPreempt", 1'b0, showPreempt)
    $display("timeout test done");
    u_op.press(3, 20);
    u_op.press(0, 20);
    u_op.save_chord();
    `CHK("showSaving", 1'b1, showSaving)
    `CHK("savedTop", 4'h3, savedTop)
    `CHK("savedSub", 3'h1, savedSub)
    `CHK("savedLevel", 1'b1, savedLevel)
    repeat (900) @(negedge mclk);
    `CHK("showSaving", 1'b1, showSaving)
    repeat (200) @(negedge mclk);
    `CHK("showSaving", 1'b0, showSaving)
    reset_n = 1'b0;
    repeat (10) @(negedge mclk);
    `CHK("topItem", 4'h0, topItem)
    reset_n = 1'b1;
    repeat (5) @(negedge mclk);
    `CHK("topItem", 4'h3, topItem)
    `CHK("subItem", 3'h1, subItem)
    `CHK("subLevel", 1'b1, subLevel)
    $display("save and restore test done");
    stop_test();
  end
endmodule : keypad_display_menu_ctrl_tb_top
`default_nettype wire
